/* include/tsf_consts.vh */
// Register offsets, field positions and reset values of the timer status flag block.
// Included by bare name from every design file of the block.
`ifndef TSF_CONSTS_VH
`define TSF_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define TSF_OFS_IRQ_ENABLE    12'h00C
`define TSF_OFS_EVENT_FLAGS   12'h010

// ****************************************
// Field positions in timer_event_flags
// ****************************************
`define TSF_BIT_CH1_EVENT     1
`define TSF_BIT_CH4_EVENT     4
`define TSF_BIT_COMMUTATION   5
`define TSF_BIT_TRIGGER       6
`define TSF_BIT_PRIMARY_BRK   7
`define TSF_BIT_SECONDARY_BRK 8
`define TSF_BIT_CH1_OVER      9
`define TSF_BIT_CH3_OVER      11

// ****************************************
// Field positions in irq_dma_enable_reg
// ****************************************
`define TSF_BIT_BREAK_IRQ_EN  7
`define TSF_IRQ_ENABLE_MSB    12

// ****************************************
// Reset values
// ****************************************
`define TSF_RST_FLAG          1'h0
`define TSF_RST_IRQ_ENABLE    13'h0000
`define TSF_RST_WORD          32'h00000000

`endif

/* rtl/tsf_sync.v */
// Two flip-flop level synchroniser, one per bit.
// Assumes inputs are levels from outside the hclk domain.
`timescale 1ns/100ps
`include "tsf_consts.vh"

module tsf_sync #(
	parameter WIDTH = 2
) (
	input  wire             hclk,
	input  wire             hresetn,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] stage1_reg;
	reg [WIDTH-1:0] stage2_reg;

	// First stage is read only by the second stage
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stage1_reg <= {WIDTH{1'b0}};
			stage2_reg <= {WIDTH{1'b0}};
		end else begin
			stage1_reg <= async_in;
			stage2_reg <= stage1_reg;
		end
	end

	assign sync_out = stage2_reg;

endmodule

/* rtl/tsf_chan_flag.v */
// Capture/compare event flag and overcapture flag of one timer channel.
// Assumes event strobes are one-cycle pulses from logic on hclk.
`timescale 1ns/100ps
`include "tsf_consts.vh"

module tsf_chan_flag #(
	parameter HAS_OVER = 1
) (
	input  wire hclk,
	input  wire hresetn,
	input  wire is_input,
	input  wire capture_evt,
	input  wire match_evt,
	input  wire retrig_evt,
	input  wire capture_read,
	input  wire sw_clr_event,
	input  wire sw_clr_over,
	output wire event_flag,
	output wire over_flag
);

	reg  event_reg;
	reg  over_reg;
	wire event_set;
	wire event_clr;
	wire over_set;
	wire event_next;
	wire over_next;

	assign event_set  = is_input ? capture_evt : (match_evt | retrig_evt); // RQ12
	assign event_clr  = sw_clr_event | (is_input & capture_read); // RQ13
	// Set beats clear so a capture in the clearing cycle is kept
	assign event_next = event_set | (event_reg & ~event_clr); // RQ3
	// Uses the flag value before this capture sets it again
	assign over_set   = (HAS_OVER != 0) & is_input & capture_evt & event_reg; // RQ1 RQ2
	assign over_next  = over_set | (over_reg & ~sw_clr_over); // RQ3

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			event_reg <= `TSF_RST_FLAG;
			over_reg  <= `TSF_RST_FLAG;
		end else begin
			event_reg <= event_next;
			over_reg  <= over_next;
		end
	end

	assign event_flag = event_reg;
	assign over_flag  = over_reg;

endmodule

/* rtl/tsf_top.v */
// Timer status flag logic with its AHB-Lite register slave.
// Assumes the counter, compare and capture datapath on hclk drives the event
// strobes; break inputs are asynchronous active-high levels.
//
// Overview of operation
// RQ1 - Overcapture only sets on input-capture channels
// RQ2 - Overcapture on capture while event flag set
// RQ3 - Writing zero clears a flag, one keeps
// RQ4 - Secondary break flag sets on active input
// RQ5 - Secondary break clear only while input inactive
// RQ6 - Secondary break flag raises irq when enabled
// RQ7 - Primary break flag sets on active input
// RQ8 - Primary break clear only while input inactive
// RQ9 - Primary break flag raises irq when enabled
// RQ10 - Trigger flag sets on every trigger event
// RQ11 - Commutation flag sets on commutation event
// RQ12 - Output channel flag sets on match, retrigger
// RQ13 - Input channel flag: capture sets, read clears
// RQ14 - Channels two to four behave like one; channel four has no overcapture flag
// RQ15 - Break irq enable is bit seven
`timescale 1ns/100ps
`include "tsf_consts.vh"

module tsf_top #(
	parameter NUM_CH   = 4,
	parameter NUM_OVER = 3,
	parameter ADDR_W   = 12
) (
	input  wire              hclk,
	input  wire              hresetn,
	input  wire              hsel,
	input  wire [ADDR_W-1:0] haddr,
	input  wire [1:0]        htrans,
	input  wire              hwrite,
	input  wire [2:0]        hsize,
	input  wire [31:0]       hwdata,
	input  wire              hready,
	output wire              hreadyout,
	output wire              hresp,
	output wire [31:0]       hrdata,
	input  wire              break_in,
	input  wire              break2_in,
	input  wire              trigger_evt,
	input  wire              commutation_evt,
	input  wire [NUM_CH-1:0] ch_is_input,
	input  wire [NUM_CH-1:0] ch_capture_evt,
	input  wire [NUM_CH-1:0] ch_match_evt,
	input  wire [NUM_CH-1:0] ch_retrig_evt,
	input  wire [NUM_CH-1:0] ch_capture_read,
	output wire              break_irq
);

	// ****************************************
	// Address decode
	// ****************************************
	function hit;
		input [ADDR_W-1:0] addr;
		input [11:0]       ofs;
		begin
			hit = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
		end
	endfunction

	// ****************************************
	// AHB-Lite slave
	// ****************************************
	reg         wr_flags_reg;
	reg         wr_enable_reg;
	reg  [31:0] hrdata_reg;
	reg  [31:0] rd_next;
	wire        access;
	wire [31:0] flags_word;
	reg  [`TSF_IRQ_ENABLE_MSB:0] irq_enable_reg;

	// Single slave, never stretches a transfer
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign access    = hsel & htrans[1] & hready;

	always @* begin
		rd_next = `TSF_RST_WORD;
		if (hit(haddr, `TSF_OFS_EVENT_FLAGS)) begin
			rd_next = flags_word;
		end else if (hit(haddr, `TSF_OFS_IRQ_ENABLE)) begin
			rd_next = {{(31-`TSF_IRQ_ENABLE_MSB){1'b0}}, irq_enable_reg};
		end
	end

	// Read data sampled at the address phase, held through the data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_flags_reg  <= 1'b0;
			wr_enable_reg <= 1'b0;
			hrdata_reg    <= `TSF_RST_WORD;
		end else begin
			wr_flags_reg  <= access & hwrite & hit(haddr, `TSF_OFS_EVENT_FLAGS);
			wr_enable_reg <= access & hwrite & hit(haddr, `TSF_OFS_IRQ_ENABLE);
			if (access & ~hwrite) begin
				hrdata_reg <= rd_next;
			end
		end
	end

	assign hrdata = hrdata_reg;

	// ****************************************
	// Interrupt enable register
	// ****************************************
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_enable_reg <= `TSF_RST_IRQ_ENABLE;
		end else if (wr_enable_reg) begin
			irq_enable_reg <= hwdata[`TSF_IRQ_ENABLE_MSB:0];
		end
	end

	// ****************************************
	// Break, trigger and commutation flags
	// ****************************************
	wire [1:0]  brk_sync;
	wire [31:0] clr_mask;
	reg         primary_break_flag_reg;
	reg         secondary_break_flag_reg;
	reg         trigger_event_flag_reg;
	reg         commutation_flag_reg;

	tsf_sync #(
		.WIDTH (2)
	) u_brk_sync (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.async_in ({break2_in, break_in}),
		.sync_out (brk_sync)
	);

	// A written zero clears, a written one leaves the bit alone
	assign clr_mask = wr_flags_reg ? ~hwdata : `TSF_RST_WORD; // RQ3

	// Active break level holds the flag set, so a clear only lands once inactive
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			primary_break_flag_reg   <= `TSF_RST_FLAG;
			secondary_break_flag_reg <= `TSF_RST_FLAG;
			trigger_event_flag_reg   <= `TSF_RST_FLAG;
			commutation_flag_reg     <= `TSF_RST_FLAG;
		end else begin
			primary_break_flag_reg   <= brk_sync[0] |
				(primary_break_flag_reg & ~clr_mask[`TSF_BIT_PRIMARY_BRK]); // RQ7 RQ8
			secondary_break_flag_reg <= brk_sync[1] |
				(secondary_break_flag_reg & ~clr_mask[`TSF_BIT_SECONDARY_BRK]); // RQ4 RQ5
			trigger_event_flag_reg   <= trigger_evt |
				(trigger_event_flag_reg & ~clr_mask[`TSF_BIT_TRIGGER]); // RQ10
			commutation_flag_reg     <= commutation_evt |
				(commutation_flag_reg & ~clr_mask[`TSF_BIT_COMMUTATION]); // RQ11
		end
	end

	// Break interrupt from either break flag
	assign break_irq = irq_enable_reg[`TSF_BIT_BREAK_IRQ_EN] &
		(primary_break_flag_reg | secondary_break_flag_reg); // RQ6 RQ9 RQ15

	// ****************************************
	// Channel flags
	// ****************************************
	wire [NUM_CH-1:0] ch_event_flag;
	wire [NUM_CH-1:0] ch_over_flag;

	genvar ci;
	generate
		for (ci = 0; ci < NUM_CH; ci = ci + 1) begin : g_ch
			// Same logic per channel; only the first channels carry overcapture
			tsf_chan_flag #(
				.HAS_OVER ((ci < NUM_OVER) ? 1 : 0)
			) u_chan ( // RQ14
				.hclk         (hclk),
				.hresetn      (hresetn),
				.is_input     (ch_is_input[ci]),
				.capture_evt  (ch_capture_evt[ci]),
				.match_evt    (ch_match_evt[ci]),
				.retrig_evt   (ch_retrig_evt[ci]),
				.capture_read (ch_capture_read[ci]),
				.sw_clr_event (clr_mask[`TSF_BIT_CH1_EVENT + ci]),
				.sw_clr_over  (clr_mask[`TSF_BIT_CH1_OVER + ci]),
				.event_flag   (ch_event_flag[ci]),
				.over_flag    (ch_over_flag[ci])
			);
		end
	endgenerate

	// ****************************************
	// Status word
	// ****************************************
	// Bits above the overcapture field and the update bit belong elsewhere
	assign flags_word = {
		{(31-`TSF_BIT_CH3_OVER){1'b0}},
		ch_over_flag[NUM_OVER-1:0],
		secondary_break_flag_reg,
		primary_break_flag_reg,
		trigger_event_flag_reg,
		commutation_flag_reg,
		ch_event_flag,
		1'b0
	};

endmodule

/* tb/tsf_brk_src.sv */
// Far-side model: the two break sources, driven as levels.
// Assumes the bench asks for a level per line through req.
`timescale 1ns/100ps
module tsf_brk_src (
	input  wire logic       hclk,
	input  wire logic [1:0] req,
	output logic            break_in,
	output logic            break2_in
);
	// *****
	// Levels
	// *****
	// One process drives both lines; lands 3 ns after the edge so the block sees a truly async level
	initial begin
		{break2_in, break_in} = 2'h0;
		forever begin
			@(posedge hclk);
			#3;
			{break2_in, break_in} <= req;
		end
	end
endmodule

/* tb/tsf_check_sva.sv */
// Port-level checks of the status flag block.
// Assumes zero wait states and word-aligned addresses.
`timescale 1ns/100ps
`include "tsf_consts.vh"
module tsf_check_sva #(
	parameter NUM_CH = 4,
	parameter ADDR_W = 12
) (
	input wire logic              hclk,
	input wire logic              hresetn,
	input wire logic              hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0]        htrans,
	input wire logic              hwrite,
	input wire logic [31:0]       hwdata,
	input wire logic [31:0]       hrdata,
	input wire logic              break_in,
	input wire logic              break2_in,
	input wire logic              trigger_evt,
	input wire logic              commutation_evt,
	input wire logic [NUM_CH-1:0] ch_is_input,
	input wire logic [NUM_CH-1:0] ch_capture_evt,
	input wire logic [NUM_CH-1:0] ch_match_evt,
	input wire logic [NUM_CH-1:0] ch_retrig_evt,
	input wire logic              break_irq
);
	// *****
	// Shadow of the break irq enable
	// *****
	logic wr_ie_reg;
	logic bie_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ie_reg <= 1'b0;
			bie_reg   <= 1'b0;
		end else begin
			if (wr_ie_reg)
				bie_reg <= hwdata[7];
			wr_ie_reg <= hsel && htrans[1] && hwrite && haddr == `TSF_OFS_IRQ_ENABLE;
		end
	end
	// *****
	// Properties
	// *****
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence rd_s;
		hsel && htrans[1] && !hwrite && haddr == `TSF_OFS_EVENT_FLAGS;
	endsequence
	sequence cap_s;
		ch_is_input[0] && ch_capture_evt[0];
	endsequence
	trig_flag_a: assert property (trigger_evt ##1 rd_s |=> hrdata[6]) else $error("trigger flag");
	comm_flag_a: assert property (commutation_evt ##1 rd_s |=> hrdata[5]) else $error("comm flag");
	match_flag_a: assert property ((!ch_is_input[1] && (ch_match_evt[1] || ch_retrig_evt[1])) ##1 rd_s
		|=> hrdata[2]) else $error("match flag");
	cap_flag_a: assert property (cap_s ##1 rd_s |=> hrdata[1]) else $error("capture flag");
	over_flag_a: assert property (cap_s ##1 cap_s ##1 rd_s |=> hrdata[9]) else $error("overcapture");
	brk_flag_a: assert property (break_in[*3] ##1 rd_s |=> hrdata[7]) else $error("break flag");
	brk2_flag_a: assert property (break2_in[*3] ##1 rd_s |=> hrdata[8]) else $error("break2 flag");
	irq_on_a: assert property (break_in[*3] ##1 bie_reg |-> break_irq) else $error("irq missing");
	irq2_on_a: assert property (break2_in[*3] ##1 bie_reg |-> break_irq) else $error("irq2 missing");
	irq_off_a: assert property (!bie_reg |-> !break_irq) else $error("irq not masked");
endmodule
bind tsf_top tsf_check_sva #(.NUM_CH(NUM_CH), .ADDR_W(ADDR_W)) u_check (.*);

/* tb/timer_status_flag_logic_bench.sv */
// Self-checking bench of the status flag block.
// Assumes zero wait states on the register bus.
`timescale 1ns/100ps
`include "tsf_consts.vh"
module timer_status_flag_logic_bench;
	// *****
	// Signals
	// *****
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        trig = 1'b0;
	logic        comm = 1'b0;
	logic [3:0]  is_in = 4'h0;
	logic [3:0]  cap = 4'h0;
	logic [3:0]  mat = 4'h0;
	logic [3:0]  ret = 4'h0;
	logic [3:0]  crd = 4'h0;
	logic [1:0]  brk_req = 2'h0;
	wire         hrdy;
	wire         hresp;
	wire  [31:0] hrdata;
	wire         brk;
	wire         brk2;
	wire         irq;
	logic [31:0] rd;
	int          n_fail = 0;
	int          checked = 0;
	int          cycles = 0;
	always #4 hclk = ~hclk;
	tsf_brk_src u_src (.hclk(hclk), .req(brk_req), .break_in(brk), .break2_in(brk2));
	tsf_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata),
		.break_in(brk), .break2_in(brk2), .trigger_evt(trig), .commutation_evt(comm), .ch_is_input(is_in),
		.ch_capture_evt(cap), .ch_match_evt(mat), .ch_retrig_evt(ret), .ch_capture_read(crd), .break_irq(irq));
	// *****
	// Tasks
	// *****
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s exp %h seen %h", name, exp, seen);
		end
	endtask
	task test_done;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		@(posedge hclk);
		while (hrdy !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hrdy !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	task rflags(input logic [31:0] exp);
		bus(1'b0, `TSF_OFS_EVENT_FLAGS, 32'h0);
		chk("flags", rd, exp);
	endtask
	// Order: capture, match, retrigger, capture read, trigger, commutation
	task pulse(input logic [17:0] v, input int n);
		{cap, mat, ret, crd, trig, comm} <= v;
		repeat (n) @(posedge hclk);
		{cap, mat, ret, crd, trig, comm} <= 18'h00000;
	endtask
	task t_reset;
		rflags(32'h0);
		bus(1'b1, 12'h020, 32'hFFFFFFFF);
		bus(1'b0, 12'h020, 32'h0);
		chk("unmapped", rd, 32'h0);
		bus(1'b1, `TSF_OFS_IRQ_ENABLE, 32'hFFFFFFFF);
		bus(1'b0, `TSF_OFS_IRQ_ENABLE, 32'h0);
		chk("irq_en", rd, 32'h00001FFF);
	endtask
	task t_output;
		// Second capture edge would raise overcapture if output mode were ignored
		pulse({4'hF, 4'hF, 4'h0, 4'h0, 2'h3}, 2);
		rflags(32'h0000007E);
		bus(1'b1, `TSF_OFS_EVENT_FLAGS, 32'hFFFFFFBF);
		chk("hresp", {31'h0, hresp}, 32'h0);
		rflags(32'h0000003E);
		bus(1'b1, `TSF_OFS_EVENT_FLAGS, 32'h0);
		pulse({4'h0, 4'h0, 4'hF, 4'hF, 2'h0}, 1);
		rflags(32'h0000001E);
		bus(1'b1, `TSF_OFS_EVENT_FLAGS, 32'h0);
	endtask
	task t_input;
		is_in <= 4'hF;
		pulse({4'hF, 4'hF, 4'h0, 4'h0, 2'h0}, 1);
		rflags(32'h0000001E);
		pulse({4'hF, 4'h0, 4'h0, 4'h0, 2'h0}, 2);
		rflags(32'h00000E1E);
		pulse({4'h0, 4'h0, 4'h0, 4'hF, 2'h0}, 1);
		rflags(32'h00000E00);
		bus(1'b1, `TSF_OFS_EVENT_FLAGS, 32'hFFFFFBFF);
		rflags(32'h00000A00);
		bus(1'b1, `TSF_OFS_EVENT_FLAGS, 32'h0);
	endtask
	task t_break;
		for (int i = 0; i < 2; i++) begin
			bus(1'b1, `TSF_OFS_IRQ_ENABLE, 32'h00000080);
			brk_req <= 2'h1 << i;
			repeat (6) @(posedge hclk);
			chk("irq_on", {31'h0, irq}, 32'h1);
			bus(1'b1, `TSF_OFS_EVENT_FLAGS, 32'h0);
			rflags(32'h00000080 << i);
			brk_req <= 2'h0;
			repeat (6) @(posedge hclk);
			bus(1'b1, `TSF_OFS_IRQ_ENABLE, 32'h0);
			rflags(32'h00000080 << i);
			chk("irq_off", {31'h0, irq}, 32'h0);
			bus(1'b1, `TSF_OFS_EVENT_FLAGS, 32'h0);
			rflags(32'h0);
		end
	endtask
	// *****
	// Run
	// *****
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 4000) begin
			n_fail++;
			test_done;
		end
	end
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_output;
		t_input;
		t_break;
		test_done;
	end
endmodule
